// ===== reset_gen_pkg.sv
// Constants and types shared by the reset generation block.
// Assumes a 10 MHz system clock and a one-cycle tick per slow RC period.
package reset_gen_pkg;

    localparam int unsigned   CLK_HZ          = 10_000_000;
    localparam int unsigned   HOLD_FIELD_W    = 7;
    localparam logic [6:0]    HOLD_FIELD_MAX  = 7'h7F;
    localparam int unsigned   HOLD_UNIT_SHIFT = 12;   // 4096 slow RC periods per unit
    localparam int unsigned   HOLD_CNT_W      = HOLD_FIELD_W + HOLD_UNIT_SHIFT;
    localparam real           SLOW_RC_PERIOD_US = 31.25;
    localparam int unsigned   GPIO_COUNT      = 32;
    localparam int unsigned   GPIO_IDX_W      = 5;
    localparam logic [4:0]    GPIO_IDX_NONE   = 5'h00;
    localparam logic          POL_ACTIVE_HIGH = 1'b1;
    localparam logic [31:0]   CPU_RESET_KEY   = 32'h05FA0004;

    // Cycles a generated reset stays high after its request drops
    localparam int unsigned   RELEASE_CYCLES  = 4;
    localparam int unsigned   RELEASE_CNT_W   = 3;

    localparam logic [31:0]   AON_START       = 32'h50000000;
    localparam logic [31:0]   AON_END         = 32'h50000FFF;
    localparam logic [31:0]   SYS_START       = 32'h07F40000;
    localparam logic [31:0]   SYS_END         = 32'h07F8FFFF;
    localparam logic [31:0]   RAD_START       = 32'h40000000;
    localparam logic [31:0]   RAD_END         = 32'h40007FFF;

    typedef enum logic [1:0] {
        REG_OTHER        = 2'b00,
        REG_OTP_COPY     = 2'b01,
        REG_DEBUG_FREEZE = 2'b10,
        REG_RADIO_CTRL   = 2'b11
    } reg_class_t;

    typedef enum logic [1:0] {
        SLEEP_NONE     = 2'b00,
        SLEEP_PLAIN    = 2'b01,
        SLEEP_EXTENDED = 2'b10,
        SLEEP_DEEP     = 2'b11
    } sleep_mode_t;

endpackage : reset_gen_pkg

// ===== level_sync.sv
// Two-flop synchroniser for one level.
// Assumes the input may change at any time relative to sys_clk_i.
`timescale 1ns/1ps
module level_sync (
    input  wire logic sys_clk_i,
    input  wire logic reset_i,
    input  wire logic async_i,
    output logic      sync_o
);
    logic stage1_ff;
    logic stage2_ff;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            stage1_ff <= 1'b0;
            stage2_ff <= 1'b0;
        end else begin
            stage1_ff <= async_i;
            stage2_ff <= stage1_ff;
        end
    end

    assign sync_o = stage2_ff;
endmodule : level_sync

// ===== reset_release.sv
// Reset output stage: follows its request at once, releases a few clocks later.
// Assumes the request is glitch free in the system clock domain.
`timescale 1ns/1ps
module reset_release (
    input  wire logic sys_clk_i,
    input  wire logic reset_i,
    input  wire logic req_i,
    output logic      rst_o
);
    logic [reset_gen_pkg::RELEASE_CNT_W-1:0] hold_ff;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i || req_i) begin
            hold_ff <= reset_gen_pkg::RELEASE_CNT_W'(reset_gen_pkg::RELEASE_CYCLES);
        end else if (hold_ff != '0) begin
            hold_ff <= hold_ff - 1'b1;
        end
    end

    assign rst_o = req_i || (hold_ff != '0);

    a_release_stretch: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        $fell(req_i) |-> rst_o [*4]) else $error("reset released too early");
endmodule : reset_release

// ===== reset_generation_and_retention.sv
// Reset generation: power-on, hardware and software reset classes,
// register-group clear outputs and sleep retention lookup.
// Assumes slow_rc_tick_i pulses once per slow RC period and that all
// configuration inputs come from flops elsewhere in the always-on logic.
`timescale 1ns/1ps

// How it works
// - Reset pad high means reset asserted.
// - Low core supply raises power-on reset until supply is good.
// - Pad or selected GPIO held for the hold delay raises power-on reset.
// - Pad shorter than hold time gives hardware reset, longer gives power-on.
// - Software reset is CPU key write OR soft_reset_request bit.
// - With hwreset_after_wake set, waking from extended/deep sleep gives hardware reset.
// - Power-on or hardware reset cold boots; software reset only reboots the CPU.
// - Power-on-only group cleared only by power-on reset.
// - Second group cleared by power-on or hardware reset, not software.
// - All other registers cleared by any reset.
// - Reset pad is always a power-on source; nothing disables it.
// - Hold factor is a 7-bit field, maximum 0x7F.
// - Hold time is factor times 4096 slow RC periods.
// - Hold counter runs on slow RC; oscillator forced on when a source asserts.
// - Pad uses default oscillator trim, GPIO source uses programmed trim.
// - Monitored GPIO keeps working as a normal I/O.
// - GPIO index selects the source pin; zero disables GPIO source.
// - Polarity bit 0 is active low, 1 is active high.
// - Always-on range retained in sleep; peripheral domain not retained.
// - OTP copy registers, debug freeze and radio control register retained.
// - Counter starts on assertion, returns to zero on early release.
// - Overlapping sources keep the count going to power-on reset.
module reset_generation_and_retention (
    input  wire logic                                   sys_clk_i,
    input  wire logic                                   reset_i,
    input  wire logic                                   supply_ok_i,
    input  wire logic                                   reset_pad_i,
    input  wire logic [reset_gen_pkg::GPIO_COUNT-1:0]   gpio_pins_i,
    input  wire logic [reset_gen_pkg::GPIO_IDX_W-1:0]   gpio_source_index_i,
    input  wire logic                                   gpio_source_polarity_i,
    input  wire logic [reset_gen_pkg::HOLD_FIELD_W-1:0] power_on_hold_count_i,
    input  wire logic                                   slow_rc_tick_i,
    input  wire logic                                   slow_rc_sw_enable_i,
    input  wire logic                                   soft_reset_request_i,
    input  wire logic                                   cpu_reset_write_i,
    input  wire logic [31:0]                            cpu_reset_data_i,
    input  wire logic                                   hwreset_after_wake_i,
    input  wire logic                                   wake_i,
    input  wire reset_gen_pkg::sleep_mode_t             sleep_mode_i,
    input  wire logic [31:0]                            query_addr_i,
    input  wire reset_gen_pkg::reg_class_t              query_class_i,
    output logic                                        poweron_reset_o,
    output logic                                        hardware_reset_o,
    output logic                                        software_reset_o,
    output logic                                        cold_boot_o,
    output logic                                        cpu_reboot_only_o,
    output logic                                        clear_poweron_group_o,
    output logic                                        clear_hardware_group_o,
    output logic                                        clear_common_group_o,
    output logic                                        slow_rc_enable_o,
    output logic                                        slow_rc_use_prog_trim_o,
    output logic                                        retained_o
);

    localparam int unsigned CW = reset_gen_pkg::HOLD_CNT_W;

    // Hold threshold in slow RC periods
    function automatic logic [CW-1:0] hold_threshold(
        input logic [reset_gen_pkg::HOLD_FIELD_W-1:0] factor
    );
        return {factor, {reset_gen_pkg::HOLD_UNIT_SHIFT{1'b0}}};
    endfunction : hold_threshold

    function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                      input logic [31:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction : in_range

    logic                   gpio_raw;
    logic                   gpio_asserted;
    logic                   pad_s;
    logic                   gpio_s;
    logic                   src_active;
    logic                   pad_prev_ff;
    logic [CW-1:0]          hold_cnt_ff;
    logic                   por_fired_ff;
    logic                   por_fire_ff;
    logic                   hw_pulse_ff;
    logic                   wake_pulse_ff;
    logic                   sw_pulse_ff;
    logic                   cpu_key_hit;
    logic                   hold_expired;
    logic                   por_req;
    logic                   hw_req;
    logic                   sw_req;
    logic                   retained_ff;

    // index zero turns the GPIO source off; polarity select
    assign gpio_raw      = gpio_pins_i[gpio_source_index_i];
    assign gpio_asserted = (gpio_source_index_i != reset_gen_pkg::GPIO_IDX_NONE) &&
                           (gpio_raw == gpio_source_polarity_i);

    // sync pad and GPIO; pins are only observed, never driven
    level_sync u_pad_sync (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .async_i   (reset_pad_i),
        .sync_o    (pad_s)
    );

    level_sync u_gpio_sync (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .async_i   (gpio_asserted),
        .sync_o    (gpio_s)
    );

    // pad active high; pad source has no enable
    assign src_active = pad_s || gpio_s;

    // oscillator forced on while any source asserts
    assign slow_rc_enable_o = slow_rc_sw_enable_i || reset_pad_i || gpio_asserted;

    // pad keeps default trim, GPIO alone uses programmed trim
    assign slow_rc_use_prog_trim_o = gpio_s && !pad_s;

    // threshold is factor times 4096 periods
    assign hold_expired = (hold_cnt_ff >= hold_threshold(power_on_hold_count_i));

    // count while any source holds, clear on release
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || !src_active) begin
            hold_cnt_ff <= '0;
        end else if (slow_rc_tick_i && !hold_expired) begin
            hold_cnt_ff <= hold_cnt_ff + 1'b1;
        end
    end

    // fire once per assertion when the hold time is reached
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || !src_active) begin
            por_fired_ff <= 1'b0;
            por_fire_ff  <= 1'b0;
        end else begin
            por_fire_ff  <= hold_expired && !por_fired_ff;
            por_fired_ff <= por_fired_ff || hold_expired;
        end
    end

    // short pad pulse gives hardware reset only
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            pad_prev_ff <= 1'b0;
            hw_pulse_ff <= 1'b0;
        end else begin
            pad_prev_ff <= pad_s;
            hw_pulse_ff <= pad_prev_ff && !pad_s && !por_fired_ff && !hold_expired;
        end
    end

    // wake from extended or deep sleep
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            wake_pulse_ff <= 1'b0;
        end else begin
            wake_pulse_ff <= wake_i && hwreset_after_wake_i &&
                             ((sleep_mode_i == reset_gen_pkg::SLEEP_EXTENDED) ||
                              (sleep_mode_i == reset_gen_pkg::SLEEP_DEEP));
        end
    end

    // CPU key write or soft_reset_request bit
    assign cpu_key_hit = cpu_reset_write_i &&
                         (cpu_reset_data_i == reset_gen_pkg::CPU_RESET_KEY);

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            sw_pulse_ff <= 1'b0;
        end else begin
            sw_pulse_ff <= cpu_key_hit || soft_reset_request_i;
        end
    end

    assign por_req = !supply_ok_i || reset_i || por_fire_ff;
    assign hw_req  = por_req || hw_pulse_ff || wake_pulse_ff;
    assign sw_req  = hw_req || sw_pulse_ff;

    reset_release u_por_rel (
        .sys_clk_i (sys_clk_i),
        .reset_i   (1'b0),
        .req_i     (por_req),
        .rst_o     (poweron_reset_o)
    );

    reset_release u_hw_rel (
        .sys_clk_i (sys_clk_i),
        .reset_i   (1'b0),
        .req_i     (hw_req),
        .rst_o     (hardware_reset_o)
    );

    reset_release u_sw_rel (
        .sys_clk_i (sys_clk_i),
        .reset_i   (1'b0),
        .req_i     (sw_req),
        .rst_o     (software_reset_o)
    );

    // cold start on power-on or hardware reset only
    assign cold_boot_o       = hardware_reset_o;
    assign cpu_reboot_only_o = software_reset_o && !hardware_reset_o;

    assign clear_poweron_group_o  = poweron_reset_o;
    assign clear_hardware_group_o = hardware_reset_o;
    assign clear_common_group_o   = software_reset_o;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            retained_ff <= 1'b0;
        end else begin
            retained_ff <= in_range(query_addr_i, reset_gen_pkg::AON_START,
                                    reset_gen_pkg::AON_END) ||
                           (in_range(query_addr_i, reset_gen_pkg::SYS_START,
                                     reset_gen_pkg::SYS_END) &&
                            ((query_class_i == reset_gen_pkg::REG_OTP_COPY) ||
                             (query_class_i == reset_gen_pkg::REG_DEBUG_FREEZE))) ||
                           (in_range(query_addr_i, reset_gen_pkg::RAD_START,
                                     reset_gen_pkg::RAD_END) &&
                            (query_class_i == reset_gen_pkg::REG_RADIO_CTRL));
        end
    end
    assign retained_o = retained_ff;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    a_count_clears: assert property (!src_active |=> hold_cnt_ff == '0)
        else $error("hold counter not cleared on release");
    a_por_on_expire: assert property (
        src_active && hold_expired && !por_fired_ff ##1 src_active
        |-> poweron_reset_o ##1 hardware_reset_o && software_reset_o)
        else $error("hold expiry did not give power-on reset");
    a_short_pad_hw: assert property (
        pad_prev_ff && !pad_s && !por_fired_ff && !hold_expired
        |=> hardware_reset_o && (supply_ok_i || poweron_reset_o))
        else $error("short pad pulse missed hardware reset");
    a_sw_key_or: assert property (cpu_key_hit || soft_reset_request_i
        |=> software_reset_o [*4])
        else $error("software reset request lost");
    a_wake_hw: assert property (wake_i && hwreset_after_wake_i &&
        sleep_mode_i == reset_gen_pkg::SLEEP_DEEP |=> hardware_reset_o)
        else $error("wake did not give hardware reset");
    a_gpio_disable: assert property (
        gpio_source_index_i == reset_gen_pkg::GPIO_IDX_NONE |-> !gpio_asserted)
        else $error("GPIO source active with index zero");
    a_osc_forced: assert property (reset_pad_i |-> slow_rc_enable_o)
        else $error("oscillator not forced on");
    a_group_nesting: assert property (clear_poweron_group_o
        |-> clear_hardware_group_o && clear_common_group_o)
        else $error("clear groups not nested");
    a_supply_por: assert property (!supply_ok_i |-> poweron_reset_o)
        else $error("low supply without power-on reset");


    // A reboot-only reset must never restart the boot sequence
    a_sw_not_cold: assert property (
        software_reset_o && !hardware_reset_o |-> !cold_boot_o && cpu_reboot_only_o)
        else $error("software reset started a cold boot");

    // One power-on per continuous assertion, however long it lasts
    a_fire_once: assert property (
        por_fired_ff |=> !por_fire_ff)
        else $error("second power-on during one assertion");

    // Counter parks at the threshold so a held source cannot wrap it
    a_count_parks: assert property (
        src_active && hold_expired |=> $stable(hold_cnt_ff) || hold_cnt_ff == '0)
        else $error("hold counter moved after expiry");

    a_count_starts: assert property (
        src_active && slow_rc_tick_i && !hold_expired |=> hold_cnt_ff != '0)
        else $error("hold counter did not start");

    // Pad source keeps the default trim even when a GPIO overlaps it
    a_trim_pad: assert property (
        pad_s |-> !slow_rc_use_prog_trim_o)
        else $error("programmed trim used with pad source");

    a_pad_always_on: assert property (
        pad_s |-> src_active)
        else $error("pad source was masked");

    a_gpio_polarity: assert property (
        gpio_source_index_i != reset_gen_pkg::GPIO_IDX_NONE &&
        gpio_raw == gpio_source_polarity_i |-> gpio_asserted)
        else $error("GPIO polarity not honoured");

    // Lookup is registered, so the answer trails the address by one clock
    a_retain_aon: assert property (
        in_range(query_addr_i, reset_gen_pkg::AON_START, reset_gen_pkg::AON_END)
        |=> retained_o)
        else $error("always-on register not retained");

    c_wake_hw: cover property (wake_pulse_ff);
    c_gpio_por: cover property (gpio_s && !pad_s ##1 por_fire_ff);
    c_pad_hw: cover property (hw_pulse_ff);
    c_sw_only: cover property (cpu_reboot_only_o);
    c_overlap: cover property (pad_s && gpio_s ##1 !pad_s && gpio_s ##[1:50] por_fire_ff);

endmodule : reset_generation_and_retention

// ===== reset_button_model.sv
// Board side of the reset inputs: a button on the reset pad and a
// supervisor output on one GPIO, both commanded by the bench.
`timescale 1ns/1ps
module reset_button_model (
    input  wire logic        pad_press_i,
    input  wire logic        gpio_press_i,
    input  wire logic        gpio_pol_i,
    input  wire logic [4:0]  gpio_sel_i,
    input  wire logic [31:0] gpio_noise_i,
    output logic             reset_pad_o,
    output logic [31:0]      gpio_pins_o
);
    // pad active high
    // A released button leaves the pad on its pull-down
    assign reset_pad_o = pad_press_i;
    // polarity of selected pin
    // Other pins keep toggling as ordinary I/O traffic
    always_comb begin
        gpio_pins_o = gpio_noise_i;
        gpio_pins_o[gpio_sel_i] = gpio_press_i ? gpio_pol_i : ~gpio_pol_i;
    end
endmodule : reset_button_model

// ===== tb_top.sv
// Self-checking bench for the reset generator.
// Assumes one slow RC tick per system clock, so factor 1 means 4096 cycles.
`timescale 1ns/1ps
module tb_top;
    logic        sys_clk_i, reset_i, supply_ok, pad_press, gpio_press, pol, tick;
    logic        sw_en, soft_req, cpu_wr, hw_wake, wake, pad, armed, prev_sw;
    logic        por, hw, sw, cold, cpu_only, c_por, c_hw, c_com, rc_en, trim, ret;
    logic [4:0]  sel;
    logic [6:0]  factor;
    logic [31:0] cpu_data, noise, qaddr, pins;
    logic [7:0]  exp_q[$];
    int          miscompares, checks;
    reset_gen_pkg::sleep_mode_t mode;
    reset_gen_pkg::reg_class_t  qclass;

    reset_button_model partner (.pad_press_i(pad_press), .gpio_press_i(gpio_press),
        .gpio_pol_i(pol), .gpio_sel_i(sel), .gpio_noise_i(noise),
        .reset_pad_o(pad), .gpio_pins_o(pins));

    reset_generation_and_retention dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .supply_ok_i(supply_ok), .reset_pad_i(pad), .gpio_pins_i(pins),
        .gpio_source_index_i(sel), .gpio_source_polarity_i(pol),
        .power_on_hold_count_i(factor), .slow_rc_tick_i(tick), .slow_rc_sw_enable_i(sw_en),
        .soft_reset_request_i(soft_req), .cpu_reset_write_i(cpu_wr),
        .cpu_reset_data_i(cpu_data), .hwreset_after_wake_i(hw_wake), .wake_i(wake),
        .sleep_mode_i(mode), .query_addr_i(qaddr), .query_class_i(qclass),
        .poweron_reset_o(por), .hardware_reset_o(hw), .software_reset_o(sw),
        .cold_boot_o(cold), .cpu_reboot_only_o(cpu_only), .clear_poweron_group_o(c_por),
        .clear_hardware_group_o(c_hw), .clear_common_group_o(c_com),
        .slow_rc_enable_o(rc_en), .slow_rc_use_prog_trim_o(trim), .retained_o(ret));

    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    task check_event(input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask : check_event

    task check_bit(input logic e, input logic g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask : check_bit

    task complete_run;
        if (exp_q.size() != 0) miscompares++;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    // Note one reset event of class {por,hw,sw}, with every output it implies
    task expect_class(input logic [2:0] c);
        exp_q.push_back({c, c[0] & ~c[1], c[1], c});
    endtask : expect_class

    // Bounded wait for the monitor to use up every note, then let resets drop
    task drain;
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 6000) begin
            @(negedge sys_clk_i);
            n++;
        end
        if (exp_q.size() != 0) begin
            miscompares++;
            exp_q.delete();
        end
        repeat (15) @(negedge sys_clk_i);
    endtask : drain

    // Pad held over [ps,pe), source pin held over [0,gn); oscillator checked early
    task hold(input int ps, input int pe, input int gn);
        int mx;
        mx = (pe > gn) ? pe : gn;
        for (int i = 0; i < mx; i++) begin
            @(negedge sys_clk_i);
            pad_press = (i >= ps && i < pe);
            gpio_press = (i < gn);
            noise = $urandom();
            if (i == 12) begin
                @(posedge sys_clk_i);
                #20;
                check_bit(pad_press | (gpio_press & (sel != 5'h00)), rc_en);
                check_bit(~pad_press & gpio_press & (sel != 5'h00), trim);
            end
        end
        @(negedge sys_clk_i);
        pad_press = 1'b0;
        gpio_press = 1'b0;
        drain();
    endtask : hold

    task query(input logic [31:0] a, input reset_gen_pkg::reg_class_t c, input logic e);
        @(negedge sys_clk_i);
        qaddr = a;
        qclass = c;
        @(posedge sys_clk_i);
        #20;
        check_bit(e, ret);
    endtask : query

    // Each rising software reset is one event; the oldest note judges it
    always @(posedge sys_clk_i) begin
        #20;
        if (armed && sw === 1'b1 && prev_sw !== 1'b1) begin
            if (exp_q.size() == 0) check_event(8'h00, {por, hw, sw, cpu_only, cold, c_por, c_hw, c_com});
            else check_event(exp_q.pop_front(), {por, hw, sw, cpu_only, cold, c_por, c_hw, c_com});
        end
        prev_sw = sw;
    end

    initial begin
        repeat (90000) @(posedge sys_clk_i);
        miscompares++;
        complete_run();
    end

    initial begin
        {reset_i, supply_ok, tick} = 3'b111;
        {pad_press, gpio_press, pol, sw_en, soft_req, cpu_wr, hw_wake, wake} = 8'h00;
        {armed, prev_sw, miscompares, checks} = '0;
        {sel, factor, cpu_data, noise, qaddr} = '0;
        factor = 7'h01;
        mode = reset_gen_pkg::SLEEP_NONE;
        qclass = reset_gen_pkg::REG_OTHER;
        void'($urandom(44));
        repeat (20) @(negedge sys_clk_i);
        reset_i = 1'b0;
        repeat (15) @(negedge sys_clk_i);
        armed = 1'b1;
        expect_class(3'b001);
        soft_req = 1'b1;
        @(negedge sys_clk_i);
        soft_req = 1'b0;
        drain();
        expect_class(3'b001);
        cpu_wr = 1'b1;
        cpu_data = reset_gen_pkg::CPU_RESET_KEY;
        @(negedge sys_clk_i);
        cpu_wr = 1'b0;
        drain();
        // A key one bit off must be ignored
        cpu_wr = 1'b1;
        cpu_data = reset_gen_pkg::CPU_RESET_KEY ^ (32'h00000001 << $urandom_range(31));
        @(negedge sys_clk_i);
        cpu_wr = 1'b0;
        drain();
        // wake in every sleep mode, then with the option off
        hw_wake = 1'b1;
        for (int m = 0; m < 5; m++) begin
            if (m == 4) hw_wake = 1'b0;
            mode = reset_gen_pkg::sleep_mode_t'((m == 4) ? 3 : m);
            if (m == 2 || m == 3) expect_class(3'b011);
            wake = 1'b1;
            @(negedge sys_clk_i);
            wake = 1'b0;
            drain();
        end
        // short and long pad presses with no source pin selected
        expect_class(3'b011);
        hold(0, 100, 0);
        expect_class(3'b111);
        hold(0, 4200, 0);
        // random pin and polarity, then pin index zero
        for (int k = 0; k < 3; k++) begin
            sel = (k == 2) ? 5'h00 : 5'(1 + $urandom_range(30));
            pol = 1'($urandom_range(1));
            if (k < 2) expect_class(3'b111);
            hold(0, 0, 4200);
        end
        // two early releases never reach the hold time
        sel = 5'h07;
        hold(0, 0, 3000);
        hold(0, 0, 3000);
        // pin then overlapping pad, joint time past threshold
        expect_class(3'b111);
        hold(2000, 4500, 3000);
        expect_class(3'b111);
        supply_ok = 1'b0;
        repeat (3) @(negedge sys_clk_i);
        supply_ok = 1'b1;
        drain();
        // retention lookup, edges of each range
        query(32'h50000010, reset_gen_pkg::REG_OTHER, 1'b1);
        query(32'h50000FFF, reset_gen_pkg::REG_OTHER, 1'b1);
        query(32'h50001000, reset_gen_pkg::REG_OTHER, 1'b0);
        query(32'h50004010, reset_gen_pkg::REG_OTHER, 1'b0);
        query(32'h07F40000, reset_gen_pkg::REG_OTP_COPY, 1'b1);
        query(32'h07F8FFFF, reset_gen_pkg::REG_DEBUG_FREEZE, 1'b1);
        query(32'h07F40000, reset_gen_pkg::REG_OTHER, 1'b0);
        query(32'h40007FFF, reset_gen_pkg::REG_RADIO_CTRL, 1'b1);
        query(32'h40000000, reset_gen_pkg::REG_OTHER, 1'b0);
        complete_run();
    end
endmodule : tb_top
